// ---- crmc_pkg.sv ----
// crmc_pkg: register offsets, field positions and reset values for the codec routing mode block
// assumes an 8-bit register port with page select supplied by the surrounding control logic
package crmc_pkg;
  localparam logic [6:0] crmc_off_headset   = 7'h0d;
  localparam logic [6:0] crmc_off_dac_power = 7'h25;
  localparam logic [6:0] crmc_off_short     = 7'h26;
  localparam logic [6:0] crmc_off_debug     = 7'h6b;
  localparam logic [6:0] crmc_off_bypass    = 7'h6c;
  localparam logic [6:0] crmc_coef_first    = 7'h01;
  localparam logic [6:0] crmc_coef_last     = 7'h34;
  localparam int crmc_coef_count            = 52;
  localparam int crmc_bit_byp_l1            = 0;
  localparam int crmc_bit_byp_l2            = 2;
  localparam int crmc_bit_byp_r1            = 4;
  localparam int crmc_bit_byp_r2            = 6;
  localparam int crmc_bit_dac_r             = 6;
  localparam int crmc_bit_dac_l             = 7;
  localparam int crmc_bit_sc_en             = 1;
  localparam int crmc_bit_sc_pd             = 2;
  localparam int crmc_bit_rec_req           = 3;
  localparam int crmc_bit_err_dis           = 2;
  localparam int crmc_bit_err_stat          = 0;
  localparam int crmc_bit_sc_left           = 7;
  localparam int crmc_bit_sc_right          = 6;
  localparam int crmc_hs_lsb                = 5;
  localparam logic [7:0] crmc_zero_byte     = 8'h00;
  localparam logic [1:0] crmc_hs_none       = 2'h0;
  localparam logic [1:0] crmc_hs_stereo     = 2'h2;
  localparam logic [1:0] crmc_hs_mono       = 2'h1;
  localparam logic [1:0] crmc_hs_headset    = 2'h3;
  localparam int crmc_off_sc_status         = 95;
endpackage

// ---- crmc_driver_guard.sv ----
// crmc_driver_guard: short-circuit latch for one high-power driver
// assumes short_seen is synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module crmc_driver_guard (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic driver_on,
  input  wire logic short_seen,
  input  wire logic sc_enable,
  input  wire logic sc_power_down,
  output logic      in_protection,
  output logic      forced_off
);
  logic seen_off;
  wire  trip     = sc_enable & sc_power_down & short_seen & driver_on;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forced_off    <= 1'b0;
      seen_off      <= 1'b0;
      in_protection <= 1'b0;
    end else begin
      in_protection <= (sc_enable & short_seen & driver_on) | forced_off | trip; // R16
      if (trip) begin
        forced_off <= 1'b1; // R17
        seen_off   <= 1'b0;
      end else if (forced_off && !driver_on) begin
        seen_off <= 1'b1; // R17
      end else if (forced_off && seen_off && driver_on) begin
        forced_off <= 1'b0; // R17
        seen_off   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- crmc_top.sv ----
// crmc_top: page-zero routing, bypass switch and record-only mode registers of the codec
// assumes a synchronous byte register port and that page selection is done outside
// Behaviour
// R1 - detected headset type readable in headset status register
// R2 - ac-coupled wiring need not separate mono from stereo headphone
// R3 - host enables short detect with power-down for differential jack sensing
// R4 - bypass bit 0 closes left first switch, opens left default switch
// R5 - bypass bit 2 closes left second switch, opens left default switch
// R6 - bypass bit 4 closes right first switch, opens right default switch
// R7 - bypass bit 6 closes right second switch, opens right default switch
// R8 - host avoids two bypass bits for one line output
// R9 - second line inputs route to output with all converters down
// R10 - host powers down both dacs first for record-only
// R11 - debug register bit 3 requests adc data through filter path
// R12 - filter path active only while both dacs are off
// R13 - record mode closes four data switches, feeds adc samples to filters
// R14 - record mode filters use page one playback coefficient locations
// R15 - filters support high, low, band pass and notch by coefficients
// R16 - short-circuit protection state readable in status register
// R17 - driver off on short stays off until commanded off then on
// R18 - filter request bit keeps its value while a dac is on
`timescale 1ns/1ns
`default_nettype none
module crmc_top
  import crmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [1:0] headset_type,
  input  wire logic       ac_coupled_mode,
  input  wire logic       left_short_seen,
  input  wire logic       right_short_seen,
  input  wire logic       bus_error_seen,
  output logic [7:0]      reg_rdata,
  output logic            left_default_switch,
  output logic            left_first_bypass_switch,
  output logic            left_second_bypass_switch,
  output logic            right_default_switch,
  output logic            right_first_bypass_switch,
  output logic            right_second_bypass_switch,
  output logic            record_path_switch_one,
  output logic            record_path_switch_two,
  output logic            record_path_switch_three,
  output logic            record_path_switch_four,
  output logic            filter_source_adc,
  output logic            left_dac_power,
  output logic            right_dac_power,
  output logic            left_driver_power,
  output logic            right_driver_power,
  output logic            short_status_left,
  output logic            short_status_right
);
  import crmc_pkg::*;

  logic [7:0] dac_power_control;
  logic [7:0] short_circuit_control;
  logic [7:0] bus_debug_and_record_path;
  logic [7:0] passive_bypass_switches;
  logic [1:0] detected_type;
  logic       bus_error_flag;
  logic       left_prot;
  logic       right_prot;
  logic       left_forced;
  logic       right_forced;

  wire wr_dac    = reg_write & (reg_addr == crmc_off_dac_power);
  wire wr_short  = reg_write & (reg_addr == crmc_off_short);
  wire wr_debug  = reg_write & (reg_addr == crmc_off_debug);
  wire wr_bypass = reg_write & (reg_addr == crmc_off_bypass);
  wire rd_debug  = reg_read & (reg_addr == crmc_off_debug);

  wire dac_l_on = dac_power_control[crmc_bit_dac_l];
  wire dac_r_on = dac_power_control[crmc_bit_dac_r];
  wire both_dacs_off = ~dac_l_on & ~dac_r_on; // R12
  wire next_record_mode =
    bus_debug_and_record_path[crmc_bit_rec_req] & both_dacs_off; // R11 R12 R18

  wire byp_l1 = passive_bypass_switches[crmc_bit_byp_l1];
  wire byp_l2 = passive_bypass_switches[crmc_bit_byp_l2];
  wire byp_r1 = passive_bypass_switches[crmc_bit_byp_r1];
  wire byp_r2 = passive_bypass_switches[crmc_bit_byp_r2];

  wire sc_en = short_circuit_control[crmc_bit_sc_en]; // R3
  wire sc_pd = short_circuit_control[crmc_bit_sc_pd]; // R3

  // mono and stereo both read as stereo when the drivers are ac-coupled
  wire [1:0] next_type = (ac_coupled_mode && headset_type == crmc_hs_mono)
                         ? crmc_hs_stereo : headset_type; // R2

  wire [7:0] headset_byte = {1'b0, detected_type, 5'h0_0}; // R1
  wire [7:0] sc_byte = {left_prot, right_prot, 6'h0_0}; // R16
  wire [7:0] debug_byte = {bus_debug_and_record_path[7:1], bus_error_flag};
  wire [6:0] sc_stat_addr = 7'(crmc_off_sc_status);

  wire [7:0] next_rdata =
    (reg_addr == crmc_off_headset)   ? headset_byte :
    (reg_addr == crmc_off_dac_power) ? dac_power_control :
    (reg_addr == crmc_off_short)     ? short_circuit_control :
    (reg_addr == crmc_off_debug)     ? debug_byte :
    (reg_addr == crmc_off_bypass)    ? passive_bypass_switches :
    (reg_addr == sc_stat_addr)       ? sc_byte : crmc_zero_byte;

  crmc_driver_guard u_left_guard (
    .clk           (clk),
    .rst           (rst),
    .driver_on     (dac_l_on),
    .short_seen    (left_short_seen),
    .sc_enable     (sc_en),
    .sc_power_down (sc_pd),
    .in_protection (left_prot),
    .forced_off    (left_forced)
  );

  crmc_driver_guard u_right_guard (
    .clk           (clk),
    .rst           (rst),
    .driver_on     (dac_r_on),
    .short_seen    (right_short_seen),
    .sc_enable     (sc_en),
    .sc_power_down (sc_pd),
    .in_protection (right_prot),
    .forced_off    (right_forced)
  );

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_power_control         <= crmc_zero_byte;
      short_circuit_control     <= crmc_zero_byte;
      bus_debug_and_record_path <= crmc_zero_byte;
      passive_bypass_switches   <= crmc_zero_byte;
    end else begin
      if (wr_dac) begin
        dac_power_control <= reg_wdata; // R10
      end
      if (wr_short) begin
        short_circuit_control <= reg_wdata; // R3
      end
      if (wr_debug) begin
        bus_debug_and_record_path <= {reg_wdata[7:1], 1'b0}; // R11 R18
      end
      if (wr_bypass) begin
        passive_bypass_switches <= reg_wdata;
      end
    end
  end

  // status capture; a new bus error wins over the read that clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      detected_type  <= crmc_hs_none;
      bus_error_flag <= 1'b0;
    end else begin
      detected_type <= next_type; // R1
      if (bus_error_seen && !bus_debug_and_record_path[crmc_bit_err_dis]) begin
        bus_error_flag <= 1'b1;
      end else if (rd_debug) begin
        bus_error_flag <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata                  <= crmc_zero_byte;
      left_default_switch        <= 1'b1;
      left_first_bypass_switch   <= 1'b0;
      left_second_bypass_switch  <= 1'b0;
      right_default_switch       <= 1'b1;
      right_first_bypass_switch  <= 1'b0;
      right_second_bypass_switch <= 1'b0;
      record_path_switch_one     <= 1'b0;
      record_path_switch_two     <= 1'b0;
      record_path_switch_three   <= 1'b0;
      record_path_switch_four    <= 1'b0;
      filter_source_adc          <= 1'b0;
      left_dac_power             <= 1'b0;
      right_dac_power            <= 1'b0;
      left_driver_power          <= 1'b0;
      right_driver_power         <= 1'b0;
      short_status_left          <= 1'b0;
      short_status_right         <= 1'b0;
    end else begin
      reg_rdata                  <= next_rdata;
      left_first_bypass_switch   <= byp_l1; // R4
      left_second_bypass_switch  <= byp_l2; // R5 R9
      left_default_switch        <= ~(byp_l1 | byp_l2); // R4 R5
      right_first_bypass_switch  <= byp_r1; // R6
      right_second_bypass_switch <= byp_r2; // R7 R9
      right_default_switch       <= ~(byp_r1 | byp_r2); // R6 R7
      record_path_switch_one     <= next_record_mode; // R13
      record_path_switch_two     <= next_record_mode; // R13
      record_path_switch_three   <= next_record_mode; // R13
      record_path_switch_four    <= next_record_mode; // R13
      filter_source_adc          <= next_record_mode; // R13 R14 R15
      left_dac_power             <= dac_l_on;
      right_dac_power            <= dac_r_on;
      left_driver_power          <= dac_l_on & ~left_forced; // R17
      right_driver_power         <= dac_r_on & ~right_forced; // R17
      short_status_left          <= left_prot; // R16
      short_status_right         <= right_prot; // R16
    end
  end
endmodule
`default_nettype wire

// ---- crmc_top_asserts.sv ----
// crmc_top_asserts: port checker for crmc_top, bound below
// assumes writes land one edge before the switch outputs move
`timescale 1ns/1ns
`default_nettype none
module crmc_asserts
  import crmc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       left_default_switch,
  input wire logic       left_first_bypass_switch,
  input wire logic       left_second_bypass_switch,
  input wire logic       right_default_switch,
  input wire logic       right_first_bypass_switch,
  input wire logic       right_second_bypass_switch,
  input wire logic       record_path_switch_one,
  input wire logic       record_path_switch_four,
  input wire logic       filter_source_adc,
  input wire logic       left_dac_power,
  input wire logic       right_dac_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_byp = reg_write && reg_addr == crmc_off_bypass;
  wire logic wr_dac = reg_write && reg_addr == crmc_off_dac_power;
  wire logic unmapped = !(reg_addr inside {crmc_off_headset, crmc_off_dac_power,
    crmc_off_short, crmc_off_debug, crmc_off_bypass, 7'(crmc_off_sc_status)});
  AST_LEFT_FIRST: assert property (wr_byp |-> ##2 left_first_bypass_switch == $past(reg_wdata[0], 2))
    else $error("left first switch wrong");
  AST_LEFT_SECOND: assert property (wr_byp |-> ##2 left_second_bypass_switch == $past(reg_wdata[2], 2))
    else $error("left second switch wrong");
  AST_RIGHT_FIRST: assert property (wr_byp |-> ##2 right_first_bypass_switch == $past(reg_wdata[4], 2))
    else $error("right first switch wrong");
  AST_RIGHT_SECOND: assert property (wr_byp |-> ##2 right_second_bypass_switch == $past(reg_wdata[6], 2))
    else $error("right second switch wrong");
  AST_LEFT_DEFAULT: assert property (left_default_switch != (left_first_bypass_switch || left_second_bypass_switch))
    else $error("left default switch wrong");
  AST_RIGHT_DEFAULT: assert property (right_default_switch != (right_first_bypass_switch || right_second_bypass_switch))
    else $error("right default switch wrong");
  AST_FILTER_DACS_OFF: assert property (filter_source_adc |-> !left_dac_power && !right_dac_power)
    else $error("filter path with a dac on");
  AST_DAC_ON_DROPS: assert property (wr_dac && reg_wdata[7:6] != 2'b00 |-> ##2 !filter_source_adc)
    else $error("filter path kept after dac on");
  AST_RECORD_SWITCHES: assert property (record_path_switch_one == filter_source_adc && record_path_switch_four == filter_source_adc)
    else $error("record switches disagree");
  AST_UNMAPPED_ZERO: assert property (unmapped |=> reg_rdata == crmc_zero_byte)
    else $error("unmapped read not zero");
  COV_BYPASS: cover property (wr_byp && reg_wdata == 8'h01);
  COV_RECORD: cover property ($rose(filter_source_adc));
  COV_DROP: cover property ($fell(filter_source_adc));
endmodule
bind crmc_top crmc_asserts u_asserts (.clk(clk), .rst(rst), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .left_default_switch(left_default_switch), .left_first_bypass_switch(left_first_bypass_switch),
  .left_second_bypass_switch(left_second_bypass_switch), .right_default_switch(right_default_switch),
  .right_first_bypass_switch(right_first_bypass_switch),
  .right_second_bypass_switch(right_second_bypass_switch),
  .record_path_switch_one(record_path_switch_one), .record_path_switch_four(record_path_switch_four),
  .filter_source_adc(filter_source_adc), .left_dac_power(left_dac_power),
  .right_dac_power(right_dac_power));
`default_nettype wire

// ---- tb_codec_routing_mode_control.sv ----
// tb_codec_routing_mode_control: self-checking bench for crmc_top
// assumes the checker is bound in from its own file
`timescale 1ns/1ns
`default_nettype none
module tb_codec_routing_mode_control;
  import crmc_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            reg_write = 1'b0;
  logic            reg_read = 1'b0;
  logic [6:0]      reg_addr = 7'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic [1:0]      headset_type = 2'h0;
  logic            ac_coupled_mode = 1'b0;
  logic [1:0]      shorts = 2'h0;
  logic            bus_err = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic [5:0] sw;
  wire logic [4:0] rec;
  wire logic [1:0] dacp;
  wire logic [1:0] drv;
  wire logic [1:0] sst;
  int              err_count = 0;
  int              total_checks = 0;
  crmc_top uut (.clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .headset_type(headset_type),
    .ac_coupled_mode(ac_coupled_mode), .left_short_seen(shorts[1]),
    .right_short_seen(shorts[0]), .bus_error_seen(bus_err), .reg_rdata(reg_rdata),
    .left_default_switch(sw[5]), .left_first_bypass_switch(sw[4]),
    .left_second_bypass_switch(sw[3]), .right_default_switch(sw[2]),
    .right_first_bypass_switch(sw[1]), .right_second_bypass_switch(sw[0]),
    .record_path_switch_one(rec[3]), .record_path_switch_two(rec[2]),
    .record_path_switch_three(rec[1]), .record_path_switch_four(rec[0]),
    .filter_source_adc(rec[4]), .left_dac_power(dacp[1]), .right_dac_power(dacp[0]),
    .left_driver_power(drv[1]), .right_driver_power(drv[0]),
    .short_status_left(sst[1]), .short_status_right(sst[0]));
  always #2 clk = ~clk;
  task end_sim;
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // expected switch states for a bypass byte, default closed unless a bypass bit is set
  function automatic logic [7:0] exp_sw(input logic [7:0] v);
    return {2'b00, ~(v[0] | v[2]), v[0], v[2], ~(v[4] | v[6]), v[4], v[6]};
  endfunction
  task t_bypass;
    logic [7:0] d;
    logic [7:0] vals [7];
    // never two bypass bits for one line output
    vals = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h14, 8'h41, 8'h00};
    chk({2'b00, sw}, 8'h24);
    foreach (vals[i]) begin
      wr(crmc_off_bypass, vals[i]);
      chk({2'b00, sw}, exp_sw(vals[i]));
      rd(crmc_off_bypass, d);
      chk(d, vals[i]);
    end
  endtask
  task t_record;
    logic [7:0] d;
    wr(crmc_off_dac_power, 8'hc0);
    wr(crmc_off_debug, 8'h08);
    chk({3'b000, rec}, 8'h00);
    rd(crmc_off_debug, d);
    chk(d & 8'h08, 8'h08);
    wr(crmc_off_dac_power, 8'h40);
    chk({3'b000, rec}, 8'h00);
    wr(crmc_off_dac_power, 8'h00);
    chk({1'b0, dacp, rec}, 8'h1f);
    wr(crmc_off_dac_power, 8'h80);
    chk({1'b0, dacp, rec}, 8'h40);
    wr(crmc_off_debug, 8'h00);
  endtask
  task t_headset;
    logic [7:0] d;
    for (int t = 0; t < 8; t++) begin
      @(posedge clk);
      headset_type <= t[1:0];
      ac_coupled_mode <= t[2];
      repeat (3) @(posedge clk);
      rd(crmc_off_headset, d);
      chk({6'b0, d[6:5]}, (t == 5) ? 8'h02 : {6'b0, t[1:0]});
    end
  endtask
  task t_short;
    logic [7:0] d;
    int n;
    wr(crmc_off_short, 8'h06);
    wr(crmc_off_dac_power, 8'hc0);
    rd(crmc_off_short, d);
    chk(d, 8'h06);
    chk({6'b0, drv}, 8'h03);
    @(posedge clk);
    shorts <= 2'b11;
    n = 0;
    while (sst !== 2'b11 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      $display("mismatch %0t short status never raised", $time);
      end_sim;
    end
    repeat (2) @(posedge clk);
    rd(7'(crmc_off_sc_status), d);
    chk({d[7:6], 4'h0, drv}, 8'hc0);
    @(posedge clk);
    shorts <= 2'b00;
    repeat (4) @(posedge clk);
    chk({6'b0, drv}, 8'h00);
    wr(crmc_off_dac_power, 8'h00);
    wr(crmc_off_dac_power, 8'hc0);
    repeat (4) @(posedge clk);
    chk({4'h0, sst, drv}, 8'h03);
  endtask
  task t_unmapped;
    logic [7:0] d;
    wr(7'h7f, 8'hff);
    rd(7'h7f, d);
    chk(d, 8'h00);
  endtask
  // bus error flag: set by a pulse, cleared by a read, masked by the disable bit
  task t_bus_error;
    logic [7:0] d;
    @(posedge clk);
    bus_err <= 1'b1;
    @(posedge clk);
    bus_err <= 1'b0;
    rd(crmc_off_debug, d);
    chk(d, 8'h01);
    rd(crmc_off_debug, d);
    chk(d, 8'h00);
    wr(crmc_off_debug, 8'h04);
    @(posedge clk);
    bus_err <= 1'b1;
    @(posedge clk);
    bus_err <= 1'b0;
    rd(crmc_off_debug, d);
    chk(d, 8'h04);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_bypass;
    t_record;
    t_headset;
    t_short;
    t_unmapped;
    t_bus_error;
    end_sim;
  end
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
